// File: pkg/tmc_regs.svh
// register map and constants of the prescaled counter block
// assumes an apb slave with 32-bit data, one aligned word per register
`ifndef TMC_REGS_SVH
`define TMC_REGS_SVH
`define TMC_OFF_CTRL 12'h000
`define TMC_OFF_VALUE 12'h004
`define TMC_OFF_FLAGS 12'h008
`define TMC_OFF_MASK 12'h00c
`define TMC_CS_MSB 2
`define TMC_OVF_BIT 0
`define TMC_PRE_TAP8 2
`define TMC_PRE_TAP64 5
`define TMC_PRE_TAP256 7
`define TMC_PRE_TAP1024 9
`define TMC_PRE_WIDTH 10
`define TMC_CTRL_RESET 3'h0
`define TMC_VALUE_RESET 8'h00
`endif

// File: pkg/tmc_pkg.sv
// types of the prescaled counter block
// assumes tmc_regs.svh holds the numbers
package tmc_pkg;
    typedef enum logic [2:0] {
        CS_STOP, CS_CLK, CS_DIV8, CS_DIV64, CS_DIV256, CS_DIV1024, CS_PIN_FALL, CS_PIN_RISE
    } tmc_clk_sel_t;
    typedef struct packed {
        logic [11:0] addr;
        logic write;
        logic [31:0] wdata;
    } tmc_req_t;
endpackage : tmc_pkg

// File: core/tmc_prescaler.sv
// free-running 10-bit prescaler with one-cycle tick taps
// assumes pclk is the oscillator clock
`include "tmc_regs.svh"
module tmc_prescaler #(
    parameter int WIDTH = `TMC_PRE_WIDTH
) (
    input wire logic pclk,
    input wire logic presetn,
    output logic [3:0] tick
);
    logic [WIDTH-1:0] cnt_q;
    logic [WIDTH-1:0] cnt_d;
    assign cnt_d = cnt_q + {{(WIDTH-1){1'b0}}, 1'b1};
    // never reset by software, so taps stay aligned to the oscillator
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end
    // a tap fires when all bits below it roll over
    assign tick[0] = &cnt_q[`TMC_PRE_TAP8:0];
    assign tick[1] = &cnt_q[`TMC_PRE_TAP64:0];
    assign tick[2] = &cnt_q[`TMC_PRE_TAP256:0];
    assign tick[3] = &cnt_q[`TMC_PRE_TAP1024:0];
    chk_tick_nesting : assert property (@(posedge pclk) disable iff (!presetn)
        tick[3] |-> tick[2] && tick[1] && tick[0]) else $error("tap nesting broken");
endmodule : tmc_prescaler

// File: core/tmc_pin_sync.sv
// two-flop synchroniser and edge detector for the count pin
// assumes the pin is asynchronous to pclk
module tmc_pin_sync (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic pin,
    output logic rise,
    output logic fall
);
    logic meta_q;
    logic sync_q;
    logic last_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            last_q <= 1'b0;
        end else begin
            meta_q <= pin;
            sync_q <= meta_q;
            last_q <= sync_q;
        end
    end
    assign rise = sync_q & ~last_q;
    assign fall = ~sync_q & last_q;
    chk_edge_excl : assert property (@(posedge pclk) disable iff (!presetn)
        !(rise && fall)) else $error("both edges at once");
endmodule : tmc_pin_sync

// File: core/tmc_counter.sv
// top of the prescaled 8-bit counter with an apb register slave
// assumes one clock pclk; count pin and port pin are asynchronous
`include "tmc_regs.svh"
module tmc_counter #(
    parameter int WIDTH = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic count_pin,
    input wire logic irq_ack,
    output logic irq
);
    ////////////////////////////////////////////////////////////////////////////////
    tmc_pkg::tmc_req_t req;
    logic wr_en;
    logic rd_en;
    logic [3:0] tick;
    logic pin_rise;
    logic pin_fall;
    logic adv;
    logic [2:0] cs_q;
    logic [WIDTH-1:0] value_q;
    logic [WIDTH-1:0] value_d;
    logic ovf_q;
    logic ovf_en_q;
    logic ovf_set;
    logic hit_ctrl;
    logic hit_value;
    logic hit_flags;
    logic hit_mask;
    logic mapped;
    logic rd_wait_q;
    logic val_wr;
    assign req = '{addr: paddr, write: pwrite, wdata: pwdata};
    // reads take one wait state so prdata is registered before pready rises
    assign pready = ~(psel & penable & ~req.write) | rd_wait_q;
    assign wr_en = psel & penable & req.write & pstrb[0];
    assign rd_en = psel & penable & ~req.write & ~rd_wait_q;
    assign val_wr = wr_en & hit_value;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_wait_q <= 1'b0;
        end else begin
            rd_wait_q <= rd_en;
        end
    end
    assign hit_ctrl = (req.addr == `TMC_OFF_CTRL);
    assign hit_value = (req.addr == `TMC_OFF_VALUE);
    assign hit_flags = (req.addr == `TMC_OFF_FLAGS);
    assign hit_mask = (req.addr == `TMC_OFF_MASK);
    assign mapped = hit_ctrl | hit_value | hit_flags | hit_mask;
    // unmapped access answers with an error, writes dropped
    assign pslverr = psel & penable & pready & ~mapped;
    ////////////////////////////////////////////////////////////////////////////////
    tmc_prescaler #(
        .WIDTH(`TMC_PRE_WIDTH)
    ) u_pre (
        .pclk(pclk),
        .presetn(presetn),
        .tick(tick)
    );
    // the pin is sampled whatever its direction, so software toggling counts
    tmc_pin_sync u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .pin(count_pin),
        .rise(pin_rise),
        .fall(pin_fall)
    );
    ////////////////////////////////////////////////////////////////////////////////
    always_comb begin
        case (tmc_pkg::tmc_clk_sel_t'(cs_q))
            tmc_pkg::CS_STOP: adv = 1'b0;
            tmc_pkg::CS_CLK: adv = 1'b1;
            tmc_pkg::CS_DIV8: adv = tick[0];
            tmc_pkg::CS_DIV64: adv = tick[1];
            tmc_pkg::CS_DIV256: adv = tick[2];
            tmc_pkg::CS_DIV1024: adv = tick[3];
            tmc_pkg::CS_PIN_FALL: adv = pin_fall;
            tmc_pkg::CS_PIN_RISE: adv = pin_rise;
            default: adv = 1'b0;
        endcase
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cs_q <= `TMC_CTRL_RESET;
        end else if (wr_en && hit_ctrl) begin
            cs_q <= req.wdata[`TMC_CS_MSB:0];
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    // a software write wins over a tick in the same cycle
    always_comb begin
        if (wr_en && hit_value) begin
            value_d = req.wdata[WIDTH-1:0];
        end else if (adv) begin
            value_d = value_q + {{(WIDTH-1){1'b0}}, 1'b1};
        end else begin
            value_d = value_q;
        end
    end
    assign ovf_set = adv && !(wr_en && hit_value) && (&value_q);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            value_q <= `TMC_VALUE_RESET;
        end else begin
            value_q <= value_d;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    // set beats clear so an overflow during the clear is kept
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ovf_q <= 1'b0;
        end else if (ovf_set) begin
            ovf_q <= 1'b1;
        end else if (irq_ack || (wr_en && hit_flags && req.wdata[`TMC_OVF_BIT])) begin
            ovf_q <= 1'b0;
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ovf_en_q <= 1'b0;
        end else if (wr_en && hit_mask) begin
            ovf_en_q <= req.wdata[`TMC_OVF_BIT];
        end
    end
    assign irq = ovf_q & ovf_en_q;
    ////////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (rd_en) begin
            if (hit_ctrl) begin
                prdata <= {29'h0000_0000, cs_q};
            end else if (hit_value) begin
                prdata <= {{(32-WIDTH){1'b0}}, value_q};
            end else if (hit_flags) begin
                prdata <= {31'h0000_0000, ovf_q};
            end else if (hit_mask) begin
                prdata <= {31'h0000_0000, ovf_en_q};
            end else begin
                prdata <= 32'h0000_0000;
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    // named steps, each used by one check
    sequence s_wrap;
        adv && !val_wr && (value_q == 8'hff);
    endsequence
    sequence s_rd_first;
        rd_en && !pready;
    endsequence
    sequence s_rd_second;
        rd_wait_q && pready;
    endsequence
    sequence s_flag_clear;
        !ovf_set && (irq_ack || (wr_en && hit_flags && req.wdata[`TMC_OVF_BIT]));
    endsequence
    chk_wrap_to_zero : assert property (@(posedge pclk) disable iff (!presetn)
        s_wrap
        |=> (value_q == 8'h00) && ovf_q)
        else $error("no wrap");
    chk_stop_holds : assert property (@(posedge pclk) disable iff (!presetn)
        (cs_q == 3'h0) && !val_wr
        |=> $stable(value_q))
        else $error("counter moved while stopped");
    chk_clk_counts : assert property (@(posedge pclk) disable iff (!presetn)
        (cs_q == 3'h1) && !val_wr
        |=> value_q == $past(value_q) + 8'h01)
        else $error("undivided mode missed a count");
    chk_div8_rate : assert property (@(posedge pclk) disable iff (!presetn)
        (cs_q == 3'h2) && !val_wr
        |=> value_q == $past(value_q) + 8'($past(tick[0])))
        else $error("divide by 8 rate wrong");
    chk_div64_rate : assert property (@(posedge pclk) disable iff (!presetn)
        (cs_q == 3'h3) && !val_wr
        |=> value_q == $past(value_q) + 8'($past(tick[1])))
        else $error("divide by 64 rate wrong");
    chk_div256_rate : assert property (@(posedge pclk) disable iff (!presetn)
        (cs_q == 3'h4) && !val_wr
        |=> value_q == $past(value_q) + 8'($past(tick[2])))
        else $error("divide by 256 rate wrong");
    chk_div1024_rate : assert property (@(posedge pclk) disable iff (!presetn)
        (cs_q == 3'h5) && !val_wr
        |=> value_q == $past(value_q) + 8'($past(tick[3])))
        else $error("divide by 1024 rate wrong");
    chk_write_load : assert property (@(posedge pclk) disable iff (!presetn)
        val_wr
        |=> value_q == $past(req.wdata[7:0]))
        else $error("write not loaded");
    chk_irq_follows : assert property (@(posedge pclk) disable iff (!presetn)
        ovf_set && ovf_en_q
        |=> irq)
        else $error("irq missing after overflow");
    chk_irq_masked : assert property (@(posedge pclk) disable iff (!presetn)
        !ovf_en_q
        |-> !irq)
        else $error("irq while masked");
    chk_flag_sticky : assert property (@(posedge pclk) disable iff (!presetn)
        ovf_q && !irq_ack && !(wr_en && hit_flags)
        |=> ovf_q)
        else $error("flag lost");
    chk_flag_quiet : assert property (@(posedge pclk) disable iff (!presetn)
        !ovf_q && !ovf_set
        |=> !ovf_q)
        else $error("flag set without overflow");
    chk_set_wins : assert property (@(posedge pclk) disable iff (!presetn)
        ovf_set
        |=> ovf_q)
        else $error("overflow not flagged");
    chk_flag_clear : assert property (@(posedge pclk) disable iff (!presetn)
        s_flag_clear
        |=> !ovf_q)
        else $error("flag not cleared");
    chk_ctrl_rsvd : assert property (@(posedge pclk) disable iff (!presetn)
        rd_en && hit_ctrl
        |=> prdata[31:3] == 29'h0000_0000)
        else $error("reserved bits nonzero");
    chk_ctrl_write : assert property (@(posedge pclk) disable iff (!presetn)
        wr_en && hit_ctrl
        |=> cs_q == $past(req.wdata[2:0]))
        else $error("select not written");
    chk_pin_rise : assert property (@(posedge pclk) disable iff (!presetn)
        (cs_q == 3'h7) && pin_rise && !val_wr
        |=> value_q != $past(value_q))
        else $error("rising pin edge not counted");
    chk_pin_fall : assert property (@(posedge pclk) disable iff (!presetn)
        (cs_q == 3'h6) && pin_fall && !val_wr
        |=> value_q != $past(value_q))
        else $error("falling pin edge not counted");
    chk_rise_only : assert property (@(posedge pclk) disable iff (!presetn)
        (cs_q == 3'h7) && !pin_rise && !val_wr
        |=> $stable(value_q))
        else $error("counted without rising edge");
    chk_fall_only : assert property (@(posedge pclk) disable iff (!presetn)
        (cs_q == 3'h6) && !pin_fall && !val_wr
        |=> $stable(value_q))
        else $error("counted without falling edge");
    chk_mask_write : assert property (@(posedge pclk) disable iff (!presetn)
        wr_en && hit_mask
        |=> ovf_en_q == $past(req.wdata[0]))
        else $error("mask not written");
    chk_read_wait : assert property (@(posedge pclk) disable iff (!presetn)
        s_rd_first
        |=> s_rd_second)
        else $error("read wait state wrong");
    chk_read_value : assert property (@(posedge pclk) disable iff (!presetn)
        rd_en && hit_value
        |=> prdata == {{(32-WIDTH){1'b0}}, $past(value_q)})
        else $error("count read wrong");
    chk_read_flags : assert property (@(posedge pclk) disable iff (!presetn)
        rd_en && hit_flags
        |=> prdata == {31'h0000_0000, $past(ovf_q)})
        else $error("flag read wrong");
    chk_unmapped_zero : assert property (@(posedge pclk) disable iff (!presetn)
        rd_en && !mapped
        |=> prdata == 32'h0000_0000)
        else $error("unmapped read not zero");
    chk_write_ready : assert property (@(posedge pclk) disable iff (!presetn)
        psel && penable && pwrite
        |-> pready)
        else $error("write stalled");
    chk_hold_prdata : assert property (@(posedge pclk) disable iff (!presetn)
        !rd_en
        |=> $stable(prdata))
        else $error("read data moved without read");
    chk_err_ready : assert property (@(posedge pclk) disable iff (!presetn)
        pslverr
        |-> pready && psel && penable)
        else $error("error outside access");
    chk_mapped_ok : assert property (@(posedge pclk) disable iff (!presetn)
        psel && penable && mapped
        |-> !pslverr)
        else $error("error on mapped register");
endmodule : tmc_counter

// File: sim/tmc_evt_src.sv
// external event source model driving the count pin
// assumes the bench calls toggle from its own process just after a clock edge
module tmc_evt_src (
    input wire logic pclk,
    output logic count_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    initial count_pin = 1'b0;
    // each level held two cycles, above the minimum spacing, so no edge can be missed
    task automatic toggle(input int n);
        repeat (n) begin
            repeat (2) @(posedge pclk);
            count_pin <= ~count_pin;
        end
    endtask : toggle
endmodule : tmc_evt_src

// File: sim/tb_top.sv
// self-checking bench of the prescaled counter
// assumes tmc_evt_src drives the count pin; apb master in this module
`include "tmc_regs.svh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, irq_ack = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready, pslverr, irq, count_pin, last_err;
    int error_cnt = 0, checked = 0, cyc = 0;
    always #5 pclk = ~pclk;
    tmc_evt_src src (.pclk(pclk), .count_pin(count_pin));
    tmc_counter dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .count_pin(count_pin), .irq_ack(irq_ack),
        .irq(irq));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic final_report();
        $display("checks %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : final_report
    // a hang counts as a mismatch
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt++;
            final_report();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    // reads see one wait state; data and error are taken at the ready edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
            output logic [31:0] r);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        r = prdata;
        last_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        apb(1'b1, a, d, r);
    endtask : wr
    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] r;
        apb(1'b0, a, 32'h0000_0000, r);
        chk(r, exp);
    endtask : rd
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_regs();
        rd(`TMC_OFF_CTRL, 32'h0000_0000);
        rd(`TMC_OFF_VALUE, 32'h0000_0000);
        rd(`TMC_OFF_FLAGS, 32'h0000_0000);
        rd(`TMC_OFF_MASK, 32'h0000_0000);
        rd(12'h010, 32'h0000_0000);
        chk(32'(last_err), 32'h0000_0001);
        wr(`TMC_OFF_CTRL, 32'h0000_00ff);
        rd(`TMC_OFF_CTRL, 32'h0000_0007);
        wr(`TMC_OFF_CTRL, 32'h0000_0000);
        $display("test regs done");
    endtask : t_regs
    // a window of exactly four tick periods holds four ticks whatever the phase
    task automatic t_rates();
        int divs[5] = '{1, 8, 64, 256, 1024};
        for (int i = 0; i < 5; i++) begin
            wr(`TMC_OFF_VALUE, 32'h0000_0000);
            wr(`TMC_OFF_CTRL, 32'(i + 1));
            repeat (4 * divs[i] - 3) @(posedge pclk);
            wr(`TMC_OFF_CTRL, 32'h0000_0000);
            repeat (20) @(posedge pclk);
            rd(`TMC_OFF_VALUE, 32'h0000_0004);
        end
        wr(`TMC_OFF_CTRL, 32'h0000_0001);
        wr(`TMC_OFF_VALUE, 32'h0000_0010);
        rd(`TMC_OFF_VALUE, 32'h0000_0012);
        wr(`TMC_OFF_CTRL, 32'h0000_0000);
        $display("test rates done");
    endtask : t_rates
    task automatic t_pin();
        logic [31:0] m[2] = '{32'h0000_0007, 32'h0000_0006};
        for (int i = 0; i < 2; i++) begin
            wr(`TMC_OFF_VALUE, 32'h0000_0000);
            wr(`TMC_OFF_CTRL, m[i]);
            src.toggle(6);
            repeat (5) @(posedge pclk);
            wr(`TMC_OFF_CTRL, 32'h0000_0000);
            rd(`TMC_OFF_VALUE, 32'h0000_0003);
        end
        $display("test pin done");
    endtask : t_pin
    // three undivided ticks from 0xfe pass through the wrap
    task automatic ovf();
        wr(`TMC_OFF_VALUE, 32'h0000_00fe);
        wr(`TMC_OFF_CTRL, 32'h0000_0001);
        wr(`TMC_OFF_CTRL, 32'h0000_0000);
    endtask : ovf
    task automatic t_irq();
        ovf();
        rd(`TMC_OFF_VALUE, 32'h0000_0001);
        rd(`TMC_OFF_FLAGS, 32'h0000_0001);
        chk(32'(irq), 32'h0000_0000);
        wr(`TMC_OFF_MASK, 32'h0000_0001);
        chk(32'(irq), 32'h0000_0001);
        wr(`TMC_OFF_FLAGS, 32'h0000_0001);
        rd(`TMC_OFF_FLAGS, 32'h0000_0000);
        chk(32'(irq), 32'h0000_0000);
        ovf();
        chk(32'(irq), 32'h0000_0001);
        irq_ack <= 1'b1;
        @(posedge pclk);
        irq_ack <= 1'b0;
        @(posedge pclk);
        chk(32'(irq), 32'h0000_0000);
        $display("test irq done");
    endtask : t_irq
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_regs();
        t_rates();
        t_pin();
        t_irq();
        final_report();
    end
endmodule : tb_top
